// *** pfl_power_fail_lockout.sv ***
// power-fail supervision, host bus lock-out and battery status bits
`timescale 1ns/1ps
module pfl_power_fail_lockout
	import pfl_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int CNT_W    = 64
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_i,
	input  wire logic             power_fail_input_n_i,
	input  wire logic             battery_supply_above_i,
	input  wire logic             battery_low_detect_i,
	input  wire pfl_bus_type      host_bus_i,
	input  wire pfl_ctrl_type     ctrl_i,
	input  wire logic             clock_start_set_i,
	input  wire logic             clock_stop_set_i,
	input  wire logic             time_save_set_i,
	input  wire logic             time_save_clear_i,
	input  wire logic [CNT_W-1:0] clock_counters_i,
	input  wire logic             int_other_i,
	input  wire logic             mfo_other_i,
	output pfl_bus_type           core_bus_o,
	output logic                  bus_locked_o,
	output logic                  power_failing_o,
	output logic                  pf_status_o,
	output logic                  standby_o,
	output logic                  interrupt_output_pin_o,
	output logic                  interrupt_oe_n_o,
	output logic                  multi_function_output_o,
	output logic                  multi_function_oe_n_o,
	output logic                  timers_run_o,
	output logic                  int_logic_run_o,
	output logic                  osc_fail_o,
	output logic                  clock_start_o,
	output logic                  low_battery_o,
	output logic                  time_save_enable_o,
	output logic [CNT_W-1:0]      time_save_data_o
);

	// ----------------------------------------
	// time base and input filter
	// ----------------------------------------
	logic tick;
	logic pf_n_stable;

	pfl_tick #(
		.CYCLES (TICK_CYC)
	) u_tick (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.tick_o     (tick)
	);

	// same filter handles both falling and returning input
	pfl_debounce #(
		.TICKS     (DEBOUNCE_TICKS),
		.RST_LEVEL (PF_N_IDLE)
	) u_pf_filter (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.tick_i     (tick),
		.level_i    (power_fail_input_n_i),
		.stable_o   (pf_n_stable)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	pfl_state_type     state_r;
	pfl_state_type     state_nxt;
	logic [TCNT_W-1:0] delay_cnt_r;
	logic [TCNT_W-1:0] delay_cnt_nxt;
	logic [TCNT_W-1:0] safety_cnt_r;
	logic [TCNT_W-1:0] safety_cnt_nxt;
	logic              failing_r;
	logic              gated_r;
	logic              gated_nxt;
	logic              standby_r;
	logic              osc_fail_r;
	logic              clk_start_r;
	logic              low_batt_r;
	logic              ts_en_r;
	logic              ts_en_nxt;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic failing;
	logic access_held;
	logic force_lock;
	logic lock_ok;
	logic delay_done;
	logic locked;
	logic standby_entry;
	logic pf_irq;
	logic int_run;
	logic int_raw;
	logic mfo_raw;
	logic batt_sense;

	function automatic logic od_oe_n(input logic level, input logic open_drain);
		// open drain only pulls low; float the high level
		od_oe_n = open_drain ? level : 1'b0;
	endfunction

	assign failing       = !pf_n_stable;
	assign access_held   = !host_bus_i.cs_n && (!host_bus_i.rd_n || !host_bus_i.wr_n);
	assign force_lock    = (safety_cnt_r == TCNT_W'(SAFETY_TICKS));
	assign lock_ok       = host_bus_i.cs_n || force_lock;
	assign delay_done    = (delay_cnt_r == TCNT_W'(DELAY_TICKS));
	assign locked        = (state_r == PFL_LOCKED) || standby_r;
	assign standby_entry = battery_supply_above_i && !standby_r;
	assign pf_irq        = gated_r && ctrl_i.pf_int_enable;
	assign int_run       = !failing_r || ctrl_i.int_pf_run;
	assign batt_sense    = ctrl_i.pf_int_enable && !ctrl_i.single_supply;

	// power-fail event on INT, or on MFO if routed there and MFO is an interrupt; others only while allowed to run
	assign int_raw = (pf_irq && !ctrl_i.pf_route_mfo) || (int_other_i && int_run);
	assign mfo_raw = ctrl_i.mfo_is_interrupt ?
		((pf_irq && ctrl_i.pf_route_mfo) || (mfo_other_i && int_run)) :
		(mfo_other_i && int_run);

	// held until chip select drops, or a held access outlasts the safety timer, so an access is not cut mid-cycle
	assign gated_nxt = failing && (gated_r || lock_ok);

	// ----------------------------------------
	// safety timer for held accesses
	// ----------------------------------------
	always_comb begin
		safety_cnt_nxt = safety_cnt_r;
		if (!failing || !access_held || gated_r) begin
			safety_cnt_nxt = '0;
		end else if (tick && !force_lock) begin
			safety_cnt_nxt = safety_cnt_r + TCNT_W'(1);
		end
	end

	// ----------------------------------------
	// lock-out sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt     = state_r;
		delay_cnt_nxt = delay_cnt_r;
		unique case (state_r)
			PFL_ONLINE: begin
				delay_cnt_nxt = '0;
				if (gated_r && ctrl_i.delay_enable) begin
					state_nxt = PFL_DELAY;
				end else if (gated_r) begin
					state_nxt = PFL_LOCKED;
				end
			end
			PFL_DELAY: begin
				if (tick && !delay_done) begin
					delay_cnt_nxt = delay_cnt_r + TCNT_W'(1);
				end
				if (!failing) begin
					state_nxt = PFL_ONLINE;
				end else if (!ctrl_i.delay_enable && lock_ok) begin
					state_nxt = PFL_LOCKED;
				end else if (delay_done && lock_ok) begin
					state_nxt = PFL_LOCKED;
				end
			end
			PFL_LOCKED: begin
				delay_cnt_nxt = '0;
				if (!failing && !standby_r) begin
					state_nxt = PFL_ONLINE;
				end
			end
			default: begin
				state_nxt     = PFL_LOCKED;
				delay_cnt_nxt = '0;
			end
		endcase
	end

	// ----------------------------------------
	// time save
	// ----------------------------------------
	// the battery switch-over wins over a software set in the same cycle
	always_comb begin
		ts_en_nxt = ts_en_r;
		if (time_save_set_i) begin
			ts_en_nxt = 1'b1;
		end
		if (time_save_clear_i || standby_entry) begin
			ts_en_nxt = 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_r      <= PFL_ONLINE;
			delay_cnt_r  <= '0;
			safety_cnt_r <= '0;
			failing_r    <= 1'b0;
			gated_r      <= 1'b0;
			standby_r    <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			delay_cnt_r  <= delay_cnt_nxt;
			safety_cnt_r <= safety_cnt_nxt;
			failing_r    <= failing;
			gated_r      <= gated_nxt;
			standby_r    <= battery_supply_above_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			osc_fail_r  <= OSC_FAIL_RST;
			clk_start_r <= CLK_START_RST;
		end else begin
			if (clock_start_set_i) begin
				osc_fail_r  <= 1'b0;
				clk_start_r <= 1'b1;
			end else if (clock_stop_set_i) begin
				clk_start_r <= 1'b0;
			end
		end
	end

	// detector is unpowered on battery or when sensing is off, so hold
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			low_batt_r <= 1'b0;
		end else if (batt_sense && !standby_r) begin
			low_batt_r <= battery_low_detect_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ts_en_r          <= TIME_SAVE_RST;
			time_save_data_o <= '0;
		end else begin
			ts_en_r <= ts_en_nxt;
			if (ts_en_r) begin
				time_save_data_o <= clock_counters_i;
			end
		end
	end

	// ----------------------------------------
	// host bus isolation
	// ----------------------------------------
	// the core sees an idle bus while locked, whatever the pins do
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			core_bus_o   <= BUS_IDLE;
			bus_locked_o <= 1'b0;
		end else begin
			core_bus_o   <= locked ? BUS_IDLE : host_bus_i;
			bus_locked_o <= locked;
		end
	end

	// ----------------------------------------
	// status and pin outputs
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			power_failing_o         <= 1'b0;
			pf_status_o             <= 1'b0;
			standby_o               <= 1'b0;
			interrupt_output_pin_o  <= 1'b0;
			interrupt_oe_n_o        <= 1'b0;
			multi_function_output_o <= 1'b0;
			multi_function_oe_n_o   <= 1'b0;
			timers_run_o            <= 1'b1;
			int_logic_run_o         <= 1'b1;
		end else begin
			power_failing_o         <= failing_r;
			pf_status_o             <= gated_r;
			standby_o               <= standby_r;
			interrupt_output_pin_o  <= int_raw;
			interrupt_oe_n_o        <= od_oe_n(int_raw, standby_r);
			multi_function_output_o <= mfo_raw;
			multi_function_oe_n_o   <= od_oe_n(mfo_raw, standby_r);
			timers_run_o            <= !failing_r || ctrl_i.timer_pf_run;
			int_logic_run_o         <= int_run;
		end
	end

	assign osc_fail_o         = osc_fail_r;
	assign clock_start_o      = clk_start_r;
	assign low_battery_o      = low_batt_r;
	assign time_save_enable_o = ts_en_r;

endmodule

// *** pfl_pkg.sv ***
// constants and carrier types for the power-fail lock-out block
package pfl_pkg;

	// ----------------------------------------
	// clock and time base
	// ----------------------------------------
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int TICK_US        = 32;
	localparam int TICK_CYCLES    = (TICK_US * 1000000) / CLK_PERIOD_PS;

	// ----------------------------------------
	// intervals counted in ticks
	// ----------------------------------------
	localparam int DEBOUNCE_MIN_US = 30;
	localparam int DEBOUNCE_TICKS  = (DEBOUNCE_MIN_US + TICK_US - 1) / TICK_US + 1;
	localparam int SAFETY_MIN_US   = 30;
	localparam int SAFETY_TICKS    = (SAFETY_MIN_US + TICK_US - 1) / TICK_US + 1;
	localparam int DELAY_US        = 480;
	localparam int DELAY_TICKS     = DELAY_US / TICK_US;
	localparam int TCNT_W          = 5;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic OSC_FAIL_RST    = 1'b1;
	localparam logic CLK_START_RST   = 1'b0;
	localparam logic PF_N_IDLE       = 1'b1;
	localparam logic TIME_SAVE_RST   = 1'b0;

	// ----------------------------------------
	// lock-out sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {
		PFL_ONLINE = 2'b00,
		PFL_DELAY  = 2'b01,
		PFL_LOCKED = 2'b11
	} pfl_state_type;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic [4:0] address_lines;
		logic [7:0] data_lines;
	} pfl_bus_type;

	typedef struct packed {
		logic pf_int_enable;
		logic pf_route_mfo;
		logic delay_enable;
		logic timer_pf_run;
		logic int_pf_run;
		logic mfo_is_interrupt;
		logic single_supply;
	} pfl_ctrl_type;

	localparam pfl_bus_type BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
		address_lines: 5'h00, data_lines: 8'h00};

endpackage

// *** pfl_tick.sv ***
// free-running time base tick divider
`timescale 1ns/1ps
module pfl_tick
	import pfl_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES
) (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	output logic      tick_o
);
	localparam int W = $clog2(CYCLES) + 1;

	logic [W-1:0] count_r;
	logic         wrap;

	assign wrap = (count_r == W'(CYCLES - 1));

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			count_r <= '0;
			tick_o  <= 1'b0;
		end else begin
			count_r <= wrap ? '0 : count_r + W'(1);
			tick_o  <= wrap;
		end
	end
endmodule

// *** pfl_debounce.sv ***
// tick-counted level filter in both directions
`timescale 1ns/1ps
module pfl_debounce
	import pfl_pkg::*;
#(
	parameter int   TICKS     = DEBOUNCE_TICKS,
	parameter logic RST_LEVEL = PF_N_IDLE
) (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic tick_i,
	input  wire logic level_i,
	output logic      stable_o
);
	logic [TCNT_W-1:0] count_r;
	logic              differ;
	logic              done;

	// first tick is partial, so the wait spreads over one tick period
	assign differ = (level_i != stable_o);
	assign done   = tick_i && (count_r == TCNT_W'(TICKS - 1));

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			count_r  <= '0;
			stable_o <= RST_LEVEL;
		end else if (!differ) begin
			count_r  <= '0;
		end else if (done) begin
			count_r  <= '0;
			stable_o <= level_i;
		end else if (tick_i) begin
			count_r  <= count_r + TCNT_W'(1);
		end
	end
endmodule

// *** pfl_checker_sva.sv ***
// assertion checker for the power-fail lock-out block
`timescale 1ns/1ps
module pfl_checker
	import pfl_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int CNT_W    = 64
) (
	input wire logic             core_clk_i,
	input wire logic             reset_i,
	input wire logic             power_fail_input_n_i,
	input wire logic             battery_supply_above_i,
	input wire pfl_bus_type      host_bus_i,
	input wire pfl_ctrl_type     ctrl_i,
	input wire logic             clock_start_set_i,
	input wire logic [CNT_W-1:0] clock_counters_i,
	input wire pfl_bus_type      core_bus_o,
	input wire logic             bus_locked_o,
	input wire logic             power_failing_o,
	input wire logic             pf_status_o,
	input wire logic             interrupt_output_pin_o,
	input wire logic             osc_fail_o,
	input wire logic             clock_start_o,
	input wire logic             time_save_enable_o,
	input wire logic [CNT_W-1:0] time_save_data_o
);
	// ----------------------------------------
	// low run length, saturating so long outages stay harmless
	// ----------------------------------------
	logic [15:0] low_cnt_r;
	always_ff @(posedge core_clk_i) begin
		if (reset_i || power_fail_input_n_i)
			low_cnt_r <= 16'h0000;
		else if (low_cnt_r != 16'hFFFF)
			low_cnt_r <= low_cnt_r + 16'h0001;
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	property p_glitch;
		$rose(power_failing_o) |-> low_cnt_r >= 16'(TICK_CYC);
	endproperty
	a_glitch: assert property (p_glitch) else $error("power fail before debounce");
	property p_fast_lock;
		$rose(power_failing_o) && !ctrl_i.delay_enable && host_bus_i.cs_n |-> ##[0:3] bus_locked_o;
	endproperty
	a_fast_lock: assert property (p_fast_lock) else $error("lock-out late");
	property p_idle;
		bus_locked_o && $past(bus_locked_o) |-> core_bus_o == BUS_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("bus passed while locked");
	property p_hold;
		bus_locked_o && !power_fail_input_n_i |=> bus_locked_o;
	endproperty
	a_hold: assert property (p_hold) else $error("unlocked with input low");
	property p_route;
		pf_status_o && $past(ctrl_i.pf_int_enable) && !$past(ctrl_i.pf_route_mfo) |-> interrupt_output_pin_o;
	endproperty
	a_route: assert property (p_route) else $error("interrupt pin missing");
	property p_osc;
		$fell(osc_fail_o) |-> $past(clock_start_set_i);
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator flag cleared");
	property p_start;
		clock_start_set_i |=> clock_start_o && !osc_fail_o;
	endproperty
	a_start: assert property (p_start) else $error("clock start ignored");
	property p_track;
		time_save_enable_o |=> time_save_data_o == $past(clock_counters_i);
	endproperty
	a_track: assert property (p_track) else $error("save store not tracking");
	property p_save_off;
		$rose(battery_supply_above_i) |=> !time_save_enable_o;
	endproperty
	a_save_off: assert property (p_save_off) else $error("time save kept in standby");
endmodule

bind pfl_power_fail_lockout pfl_checker #(.TICK_CYC(TICK_CYC), .CNT_W(CNT_W)) i_chk (.*);

// *** pfl_host_model.sv ***
// host processor model running read or write cycles on the bus
`timescale 1ns/1ps
module pfl_host_model
	import pfl_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        start_i,
	input  wire logic        write_i,
	input  wire logic [7:0]  hold_i,
	input  wire logic [12:0] addr_data_i,
	output pfl_bus_type      bus_o = BUS_IDLE
);
	logic [7:0] left_r = 8'h00;
	// strobes stay steady for the whole cycle, released lines invert
	always_ff @(posedge core_clk_i) begin
		if (start_i && left_r == 8'h00) begin
			left_r <= hold_i;
			bus_o  <= '{1'b0, write_i, !write_i, addr_data_i[12:8], addr_data_i[7:0]};
		end else if (left_r > 8'h01) begin
			left_r <= left_r - 8'h01;
		end else begin
			left_r <= 8'h00;
			bus_o  <= '{1'b1, 1'b1, 1'b1, ~bus_o.address_lines, ~bus_o.data_lines};
		end
	end
endmodule

// *** tb.sv ***
// self-checking bench for the power-fail lock-out block
`timescale 1ns/1ps
module tb;
	import pfl_pkg::*;
	localparam int TC = 8;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic pf_n = 1'b1, bat_above = 1'b0, bat_low = 1'b0;
	logic cs_set = 1'b0, ts_set = 1'b0, ts_clr = 1'b0;
	logic h_start = 1'b0, h_wr = 1'b0;
	logic [7:0] h_hold = 8'h01;
	logic [12:0] h_ad = 13'h0000;
	logic [63:0] cnt = 64'h0, ts_data;
	logic [15:0] lfsr = 16'h7129;
	pfl_ctrl_type ctrl = '0;
	pfl_bus_type host_bus, core_bus;
	logic locked, failing, pf_stat, stby, int_pin, mfo_pin, osc, clk_run, low_bat, ts_en;
	logic int_oe_n, mfo_oe_n, tmr_run, int_run;
	int miscompares = 0;
	int cmp_count = 0;
	int n;
	always #2.5 core_clk_i = ~core_clk_i;
	pfl_host_model i_host (.core_clk_i(core_clk_i), .start_i(h_start), .write_i(h_wr), .hold_i(h_hold),
		.addr_data_i(h_ad), .bus_o(host_bus));
	pfl_power_fail_lockout #(.TICK_CYC(TC)) i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.power_fail_input_n_i(pf_n), .battery_supply_above_i(bat_above), .battery_low_detect_i(bat_low),
		.host_bus_i(host_bus), .ctrl_i(ctrl), .clock_start_set_i(cs_set), .clock_stop_set_i(1'b0),
		.time_save_set_i(ts_set), .time_save_clear_i(ts_clr), .clock_counters_i(cnt), .int_other_i(1'b0),
		.mfo_other_i(1'b0), .core_bus_o(core_bus), .bus_locked_o(locked), .power_failing_o(failing),
		.pf_status_o(pf_stat), .standby_o(stby), .interrupt_output_pin_o(int_pin), .interrupt_oe_n_o(int_oe_n),
		.multi_function_output_o(mfo_pin), .multi_function_oe_n_o(mfo_oe_n), .timers_run_o(tmr_run),
		.int_logic_run_o(int_run),
		.osc_fail_o(osc), .clock_start_o(clk_run), .low_battery_o(low_bat), .time_save_enable_o(ts_en),
		.time_save_data_o(ts_data));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic rnd();
		lfsr = lfsr_next(lfsr);
	endtask
	function automatic logic in_win(input int v, input int lo, input int hi);
		return v >= lo && v <= hi;
	endfunction
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// bounded wait; running out ends the run
	task automatic wait_lock(input logic v, input int lim);
		for (n = 0; n < lim && locked !== v; n++)
			step(1);
		if (locked !== v) begin
			$display("CHECK FAILED lock wait expected %b seen %b", v, locked);
			miscompares++;
			complete_run();
		end
	endtask
	task automatic host_cycle(input logic [7:0] hold);
		rnd();
		h_ad = lfsr[12:0];
		h_wr = lfsr[13];
		h_hold = hold;
		h_start = 1'b1;
		step(1);
		h_start = 1'b0;
	endtask
	task automatic fail_lock(input int lo, input int hi);
		pf_n = 1'b0;
		wait_lock(1'b1, hi + 4);
		check("lock time", in_win(n, lo, hi), 1'b1);
	endtask
	task automatic restore();
		host_cycle(8'h04);
		step(int'(lfsr[5:0]));
		check("bus idle", core_bus, BUS_IDLE);
		check("still locked", locked, 1'b1);
		pf_n = 1'b1;
		wait_lock(1'b0, 2 * TC + 8);
		check("unlock time", in_win(n, TC, 2 * TC + 4), 1'b1);
		step(2);
		check("status clear", pf_stat, 1'b0);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		step(4);
		reset_i = 1'b0;
		check("osc fail", osc, 1'b1);
		check("clock start", clk_run, 1'b0);
		for (int i = 0; i < 4; i++) begin
			rnd();
			pf_n = 1'b0;
			step(int'(lfsr[1:0]) + 1);
			pf_n = 1'b1;
			step(2 * TC);
			check("glitch", failing, 1'b0);
		end
		ctrl.mfo_is_interrupt = 1'b1;
		for (int m = 0; m < 3; m++) begin
			ctrl.pf_int_enable = (m != 2);
			ctrl.pf_route_mfo = (m == 1);
			ctrl.timer_pf_run = (m == 1);
			ctrl.int_pf_run = (m == 2);
			fail_lock(TC + 1, 2 * TC + 6);
			check("timers run", tmr_run, m == 1);
			check("int logic run", int_run, m == 2);
			check("int driven", int_oe_n, 1'b0);
			check("mfo driven", mfo_oe_n, 1'b0);
			check("int pin", int_pin, m == 0);
			check("mfo pin", mfo_pin, m == 1);
			check("status", pf_stat, 1'b1);
			restore();
		end
		ctrl.pf_int_enable = 1'b1;
		ctrl.pf_route_mfo = 1'b0;
		ctrl.delay_enable = 1'b1;
		fail_lock(15 * TC, 17 * TC + 8);
		restore();
		pf_n = 1'b0;
		step(2 * TC + 4);
		check("window open", locked, 1'b0);
		ctrl.delay_enable = 1'b0;
		wait_lock(1'b1, 4);
		restore();
		host_cycle(8'h60);
		fail_lock(2 * TC + 2, 4 * TC + 8);
		restore();
		bat_low = 1'b1;
		step(2);
		check("low battery", low_bat, 1'b1);
		ctrl.pf_int_enable = 1'b0;
		bat_low = 1'b0;
		step(2);
		check("low battery held", low_bat, 1'b1);
		ctrl.pf_int_enable = 1'b1;
		ctrl.single_supply = 1'b1;
		step(2);
		check("single supply", low_bat, 1'b1);
		ctrl.single_supply = 1'b0;
		step(2);
		check("low battery gone", low_bat, 1'b0);
		ts_set = 1'b1;
		step(1);
		ts_set = 1'b0;
		rnd();
		cnt = {4{lfsr}};
		step(3);
		check("save tracks", ts_data, cnt);
		ts_clr = 1'b1;
		step(1);
		ts_clr = 1'b0;
		cnt = ~cnt;
		step(3);
		check("save frozen", ts_data, ~cnt);
		ts_set = 1'b1;
		step(1);
		ts_set = 1'b0;
		bat_above = 1'b1;
		step(3);
		check("save off", ts_en, 1'b0);
		check("standby", stby, 1'b1);
		check("standby lock", locked, 1'b1);
		bat_above = 1'b0;
		wait_lock(1'b0, 8);
		check("main supply", stby, 1'b0);
		check("osc kept", osc, 1'b1);
		cs_set = 1'b1;
		step(1);
		cs_set = 1'b0;
		step(1);
		check("osc cleared", osc, 1'b0);
		check("clock running", clk_run, 1'b1);
		complete_run();
	end
endmodule
